/* File: hw/sfs_pkg.sv */
// ****************************************************************
// Shared constants for the flow-through burst memory port
// ****************************************************************
package sfs_pkg;

   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int SFS_ADDR_W = 19;            // 512K locations
   localparam int SFS_LANE_W = 9;             // Bits per byte lane
   localparam int SFS_LANES = 2;              // Byte lanes per word
   localparam int SFS_DATA_W = 18;            // Word width
   localparam int SFS_DEPTH = 524288;         // Locations
   localparam int SFS_BURST_W = 2;            // Burst counter width
   localparam int SFS_BASE_W = 17;            // Address above the counter
   localparam int SFS_SYNC_N = 3;             // Stages of an input synchroniser

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic SFS_OE_N_RST = 1'h1;      // Drivers off until seen low
   localparam logic SFS_MODE_RST = 1'h1;      // Interleaved until strap seen
   localparam logic [1:0] SFS_CNT_RST = 2'h0; // Burst counter after reset

   // ****************************************************************
   // Burst order strap levels
   // ****************************************************************
   localparam logic SFS_ORDER_LINEAR = 1'h0;  // Strap grounded

   // ****************************************************************
   // Access phase
   // ****************************************************************
   typedef enum logic [1:0] {
      SFS_PH_IDLE = 2'b00,                    // Deselected
      SFS_PH_READ = 2'b01,                    // Read access or burst
      SFS_PH_WRITE = 2'b10                    // Write access or burst
   } sfs_phase_e;

endpackage

/* File: hw/sfs_sram_port.sv */
`timescale 1ns/1ps
module sfs_sram_port
   import sfs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Address and burst control
   input wire logic [SFS_ADDR_W-1:0] addr,
   input wire logic burst_step_or_load,
   input wire logic clock_qualifier_n,
   // Chip selects
   input wire logic chip_sel_low_first,
   input wire logic chip_sel_high,
   input wire logic chip_sel_low_second,
   // Write control
   input wire logic write_en_n,
   input wire logic byte_lane0_write_n,
   input wire logic byte_lane1_write_n,
   // Asynchronous pins
   input wire logic output_enable_n,
   input wire logic burst_order_strap,
   // Data pins, split into in, out and enable
   input wire logic [SFS_DATA_W-1:0] dq_in,
   output logic [SFS_DATA_W-1:0] dq_out,
   output logic dq_oe,
   // Read data stream through the two-entry buffer
   output logic [SFS_DATA_W-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic buf_ready
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      sfs_phase_e ph;                          // Current access kind
      logic [SFS_BASE_W-1:0] base;             // Upper address of burst
      logic [SFS_BURST_W-1:0] start;           // Seed of burst counter
      logic [SFS_BURST_W-1:0] cnt;             // Steps taken in burst
      logic wp;                                // Write data due next edge
      logic [SFS_ADDR_W-1:0] wp_addr;          // Location of pending write
      logic [SFS_LANES-1:0] wp_lane;           // Lanes of pending write
      logic emerge;                            // First access after deselect
      logic rd_drv;                            // Read data may be driven
      logic [SFS_DATA_W-1:0] dq;               // Data pin output
      logic oe;                                // Data pin enable
      logic [SFS_SYNC_N-1:0] oe_s;             // Output enable synchroniser
      logic oe_n_f;                            // Filtered output enable
      logic [SFS_SYNC_N-1:0] md_s;             // Strap synchroniser
      logic md_f;                              // Filtered burst order
      logic out_v;                             // Buffer head valid
      logic [SFS_DATA_W-1:0] out_d;            // Buffer head data
      logic sk_v;                              // Buffer second entry valid
      logic [SFS_DATA_W-1:0] sk_d;             // Buffer second entry data
      logic rdy;                               // Buffer can take a word
   } sfs_state_s;

   // Reset image of the state
   localparam sfs_state_s SFS_RST = '{
      ph: SFS_PH_IDLE,
      base: '0,
      start: SFS_CNT_RST,
      cnt: SFS_CNT_RST,
      wp: 1'h0,
      wp_addr: '0,
      wp_lane: '0,
      emerge: 1'h0,
      rd_drv: 1'h0,
      dq: '0,
      oe: 1'h0,
      oe_s: {SFS_SYNC_N{SFS_OE_N_RST}},
      oe_n_f: SFS_OE_N_RST,
      md_s: {SFS_SYNC_N{SFS_MODE_RST}},
      md_f: SFS_MODE_RST,
      out_v: 1'h0,
      out_d: '0,
      sk_v: 1'h0,
      sk_d: '0,
      rdy: 1'h1
   };

   sfs_state_s state_reg;                      // Registered state
   sfs_state_s state_next;                     // Next state

   // Storage, one word of lanes per location
   logic [SFS_LANES-1:0][SFS_LANE_W-1:0] mem [0:SFS_DEPTH-1];
   logic [SFS_LANES-1:0] mem_we;               // Lane write strobes
   logic [SFS_ADDR_W-1:0] mem_wa;              // Write location
   logic [SFS_DATA_W-1:0] mem_wd;              // Write data

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Low address bits of a burst step in the chosen order
   function automatic logic [SFS_BURST_W-1:0] burst_low(
      input logic order,
      input logic [SFS_BURST_W-1:0] seed,
      input logic [SFS_BURST_W-1:0] step
   );
      // Linear order wraps inside the group of four
      if (order == SFS_ORDER_LINEAR) begin
         burst_low = SFS_BURST_W'(seed + step);
      end else begin
         burst_low = seed ^ step;
      end
   endfunction

   // Decode of the three chip selects
   function automatic logic chip_selected(
      input logic low_a,
      input logic high_b,
      input logic low_c
   );
      chip_selected = ~low_a & high_b & ~low_c;
   endfunction

   // Filtered level: changes once stages two and three agree
   function automatic logic sync_filter(
      input logic [SFS_SYNC_N-1:0] s,
      input logic prev
   );
      if (s[2] == s[1]) begin
         sync_filter = s[2];
      end else begin
         sync_filter = prev;
      end
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic go;                                   // Qualified edge
   logic acc;                                  // Access at this edge
   logic is_rd;                                // Access is a read
   logic pop;                                  // Buffer head taken
   logic [SFS_ADDR_W-1:0] a;                   // Location of this access
   logic [SFS_DATA_W-1:0] rdat;                // Word read for this access

   // Whole next-state computation
   always_comb begin
      state_next = state_reg;
      mem_we = '0;
      mem_wa = state_reg.wp_addr;
      mem_wd = dq_in;
      acc = 1'h0;
      is_rd = 1'h0;
      a = addr;
      rdat = '0;

      // Asynchronous pins pass three stages, first read only by second
      state_next.oe_s = {state_reg.oe_s[1:0], output_enable_n};
      state_next.oe_n_f = sync_filter(state_reg.oe_s, state_reg.oe_n_f);
      state_next.md_s = {state_reg.md_s[1:0], burst_order_strap};
      state_next.md_f = sync_filter(state_reg.md_s, state_reg.md_f);

      // Edge acts only with qualifier low and room in the buffer
      go = ~clock_qualifier_n & state_reg.rdy;

      if (go) begin
         // Data phase of the write taken one edge before
         if (state_reg.wp) begin
            mem_we = state_reg.wp_lane;
         end
         state_next.wp = 1'h0;

         if (burst_step_or_load) begin
            // Advance: only inside a running burst
            if (state_reg.ph != SFS_PH_IDLE) begin
               acc = 1'h1;
               is_rd = (state_reg.ph == SFS_PH_READ);
               // Counter wraps after the fourth word
               state_next.cnt = SFS_BURST_W'(state_reg.cnt + 2'h1);
               a = {state_reg.base,
                    burst_low(state_reg.md_f, state_reg.start, state_next.cnt)};
            end
            // Advance while deselected does nothing
         end else if (chip_selected(chip_sel_low_first, chip_sel_high,
                                    chip_sel_low_second)) begin
            // Load of a fresh address
            acc = 1'h1;
            is_rd = write_en_n;
            a = addr;
            state_next.base = addr[SFS_ADDR_W-1:SFS_BURST_W];
            state_next.start = addr[SFS_BURST_W-1:0];
            state_next.cnt = SFS_CNT_RST;
            state_next.ph = write_en_n ? SFS_PH_READ : SFS_PH_WRITE;
         end else begin
            // Deselect: no access, burst forgotten
            state_next.ph = SFS_PH_IDLE;
         end

         // First access after a deselect
         state_next.emerge = acc & (state_reg.ph == SFS_PH_IDLE);

         if (acc & ~is_rd) begin
            // Write address now, data at the next qualified edge
            state_next.wp = 1'h1;
            state_next.wp_addr = a;
            state_next.wp_lane = ~{byte_lane1_write_n, byte_lane0_write_n};
         end

         if (acc & is_rd) begin
            // Flow-through read with forwarding of the write in flight
            rdat = mem[a];
            if (state_reg.wp && state_reg.wp_addr == a) begin
               for (int i = 0; i < SFS_LANES; i++) begin
                  if (state_reg.wp_lane[i]) begin
                     rdat[i*SFS_LANE_W +: SFS_LANE_W] = dq_in[i*SFS_LANE_W +: SFS_LANE_W];
                  end
               end
            end
            state_next.dq = rdat;
         end

         // Drivers only for reads, not on the emerge cycle
         state_next.rd_drv = acc & is_rd & ~state_next.emerge;
      end

      // Output enable acts in every cycle, stalled or not
      state_next.oe = state_next.rd_drv & ~state_next.oe_n_f;

      // ****************************************************************
      // Two-entry read buffer
      // ****************************************************************
      pop = state_reg.out_v & rd_ready;
      if (state_reg.sk_v) begin
         // Second entry moves up when the head leaves
         if (pop) begin
            state_next.out_d = state_reg.sk_d;
            state_next.sk_v = 1'h0;
         end
      end else if (go & acc & is_rd) begin
         // New word goes to head, or to second entry if head is stuck
         if (!state_reg.out_v || pop) begin
            state_next.out_d = rdat;
            state_next.out_v = 1'h1;
         end else begin
            state_next.sk_d = rdat;
            state_next.sk_v = 1'h1;
         end
      end else if (pop) begin
         // Head drained with nothing behind it
         state_next.out_v = 1'h0;
      end
      // Full buffer holds the port as if the qualifier were high
      state_next.rdy = ~state_next.sk_v;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Register the whole state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= SFS_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Storage writes
   // ****************************************************************
   // No reset: contents are undefined until written
   // Lane-wise write, unselected lanes keep their contents
   always_ff @(posedge clk) begin
      for (int i = 0; i < SFS_LANES; i++) begin
         if (mem_we[i]) begin
            mem[mem_wa][i] <= mem_wd[i*SFS_LANE_W +: SFS_LANE_W];
         end
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign dq_out = state_reg.dq;
   assign dq_oe = state_reg.oe;
   assign rd_data = state_reg.out_d;
   assign rd_valid = state_reg.out_v;
   assign buf_ready = state_reg.rdy;

endmodule

/* File: verification/sfs_chk.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module sfs_chk
   import sfs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic burst_step_or_load,
   input wire logic clock_qualifier_n,
   input wire logic chip_sel_low_first,
   input wire logic chip_sel_high,
   input wire logic chip_sel_low_second,
   input wire logic write_en_n,
   input wire logic output_enable_n,
   // Outputs and stream
   input wire logic [SFS_DATA_W-1:0] dq_out,
   input wire logic dq_oe,
   input wire logic [SFS_DATA_W-1:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic buf_ready
);
   wire q = !clock_qualifier_n && buf_ready; // Qualified edge
   wire sel = !chip_sel_low_first && chip_sel_high && !chip_sel_low_second; // Selected
   wire ld = q && !burst_step_or_load; // Load or deselect
   logic idle_reg; // Last qualified op deselected
   // Track deselect for the emerge cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) idle_reg <= 1'h1;
      else if (ld) idle_reg <= !sel;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_unqual_hold: assert property (clock_qualifier_n |=> $stable(dq_out))
      else $error("dq_out moved on unqualified edge");
   chk_stall_hold: assert property (!buf_ready |=> $stable(dq_out))
      else $error("dq_out moved while buffer full");
   chk_read_push: assert property (ld && sel && write_en_n |=> rd_valid)
      else $error("read word not offered");
   chk_buf_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("stalled read word lost");
   chk_write_off: assert property (ld && sel && !write_en_n |=> !dq_oe)
      else $error("drivers on after write load");
   chk_desel_off: assert property (ld && !sel |=> !dq_oe)
      else $error("drivers on after deselect");
   chk_emerge_off: assert property (ld && sel && idle_reg |=> !dq_oe)
      else $error("drivers on in emerge cycle");
   chk_adv_idle: assert property (q && burst_step_or_load && idle_reg |=> !dq_oe)
      else $error("advance while deselected drove pins");
   chk_oe_float: assert property (output_enable_n [*6] |-> !dq_oe)
      else $error("drivers on with output enable high");
endmodule
bind sfs_sram_port sfs_chk sfs_chk_inst (.clk(clk), .arst_n(arst_n),
   .burst_step_or_load(burst_step_or_load), .clock_qualifier_n(clock_qualifier_n),
   .chip_sel_low_first(chip_sel_low_first), .chip_sel_high(chip_sel_high),
   .chip_sel_low_second(chip_sel_low_second), .write_en_n(write_en_n),
   .output_enable_n(output_enable_n), .dq_out(dq_out), .dq_oe(dq_oe), .rd_data(rd_data),
   .rd_valid(rd_valid), .rd_ready(rd_ready), .buf_ready(buf_ready));

/* File: verification/sfs_sink.sv */
`timescale 1ns/1ps
// ****************************************
// Read stream sink with random stalls
// ****************************************
module sfs_sink
   import sfs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Stream
   input wire logic [SFS_DATA_W-1:0] rd_data,
   input wire logic rd_valid,
   output logic rd_ready,
   // Forced stall
   input wire logic hold
);
   logic [SFS_DATA_W-1:0] got[$]; // Words taken
   int seed = 32'h03ecada9; // Stall pattern seed
   initial rd_ready = 1'h0;
   // Take words, stall one edge in four
   always @(posedge clk) begin
      if (arst_n && rd_valid && rd_ready) got.push_back(rd_data);
      rd_ready <= #1 !hold && ($random(seed) % 4 != 0);
   end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import sfs_pkg::*;
   // ****************************************
   // Signals and model state
   // ****************************************
   logic clk, arst_n = 0, sol = 0, qn = 1, wen = 1, oen = 1, strap = 1, hold = 0;
   logic [2:0] cs = 3'h0; // First, high, second
   logic [1:0] ln = 2'h3; // Lane selects
   logic [SFS_ADDR_W-1:0] addr = '0, a, b, cur, base, pa;
   logic [SFS_DATA_W-1:0] din = '0, dout, rdd, mem[int], exq[$];
   logic oe, rdv, rdy, bufr, pv = 0, oe_on = 0, emg;
   logic [1:0] pl;
   int st = 0, nb, m, i, seed = 32'h03ecada9, bad_count = 0, checked = 0;
   sfs_sram_port sfs_sram_port_inst (.clk(clk), .arst_n(arst_n), .addr(addr),
      .burst_step_or_load(sol), .clock_qualifier_n(qn), .chip_sel_low_first(cs[2]),
      .chip_sel_high(cs[1]), .chip_sel_low_second(cs[0]), .write_en_n(wen),
      .byte_lane0_write_n(ln[0]), .byte_lane1_write_n(ln[1]), .output_enable_n(oen),
      .burst_order_strap(strap), .dq_in(din), .dq_out(dout), .dq_oe(oe), .rd_data(rdd),
      .rd_valid(rdv), .rd_ready(rdy), .buf_ready(bufr));
   sfs_sink sfs_sink_inst (.clk(clk), .arst_n(arst_n), .rd_data(rdd), .rd_valid(rdv),
      .rd_ready(rdy), .hold(hold));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic conclude;
      $display("Counts: checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One qualified edge: k 0 deselect, 1 read load, 2 write load, 3 advance
   task automatic op(input int k, input logic [18:0] ad, input logic [1:0] l, input logic [17:0] d);
      logic qf;
      int j;
      addr = ad;
      ln = l;
      din = d;
      sol = (k == 3);
      wen = (k != 2);
      cs = k ? 3'h2 : 3'h2 ^ 3'(1 + {$random(seed)} % 7);
      qn = 0;
      for (j = 0; j < 40; j++) begin
         @(negedge clk);
         qf = bufr;
         @(posedge clk);
         #1;
         if (qf === 1'b1) break;
      end
      chk("buf_ready", 18'h1, 18'(qf));
      if (pv) begin
         if (!pl[0]) mem[pa][8:0] = d[8:0];
         if (!pl[1]) mem[pa][17:9] = d[17:9];
         pv = 0;
      end
      if (k == 0 || (k == 3 && st == 0)) begin
         st = 0;
         chk("dq_oe", 18'h0, 18'(oe));
      end else begin
         if (k != 3) begin
            emg = (st == 0);
            st = k;
            base = ad;
            nb = 0;
         end else begin
            nb++;
            emg = 0;
         end
         cur = {base[18:2], strap ? base[1:0] ^ 2'(nb) : base[1:0] + 2'(nb)};
         if (st == 2) begin
            pv = 1;
            pa = cur;
            pl = l;
         end else begin
            exq.push_back(mem[cur]);
            chk("dq_out", mem[cur], dout);
            chk("dq_oe", 18'(oe_on && !emg), 18'(oe));
         end
      end
   endtask
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (2) @(posedge clk);
      #1 arst_n = 1;
      for (m = 0; m < 2; m++) begin
         strap = m[0];
         oen = 0;
         repeat (8) @(posedge clk);
         #1 oe_on = 1;
         a = 19'($random(seed));
         op(2, a, 2'h0, 18'h0);
         for (i = 0; i < 3; i++) op(3, a, 2'h0, 18'($random(seed)));
         op(0, a, 2'h0, 18'($random(seed)));
         op(3, a, 2'h0, 18'h0);
         op(1, a, 2'h0, 18'h0);
         qn = 1;
         repeat (3) @(posedge clk);
         #1 chk("dq_out", mem[cur], dout);
         for (i = 0; i < 3; i++) op(3, a, 2'($random(seed)), 18'h0);
         op(0, a, 2'h0, 18'h0);
         $display("Burst test %0d done", m);
      end
      b = 19'($random(seed));
      op(2, b, 2'h0, 18'($random(seed)));
      for (i = 0; i < 4; i++) op(2, b, i[1:0], 18'($random(seed)));
      op(0, b, 2'h0, 18'($random(seed)));
      op(1, b, 2'h0, 18'h0);
      op(0, b, 2'h0, 18'h0);
      $display("Lane test done");
      repeat (10) @(posedge clk);
      #1 hold = 1;
      op(1, a, 2'h0, 18'h0);
      op(3, a, 2'h0, 18'h0);
      qn = 1;
      @(posedge clk);
      #1 chk("buf_ready", 18'h0, 18'(bufr));
      hold = 0;
      op(0, a, 2'h0, 18'h0);
      $display("Buffer test done");
      oen = 1;
      oe_on = 0;
      repeat (6) @(posedge clk);
      #1 op(1, b, 2'h0, 18'h0);
      op(1, b, 2'h0, 18'h0);
      op(0, b, 2'h0, 18'h0);
      repeat (20) @(posedge clk);
      foreach (exq[j]) chk("rd_data", exq[j], sfs_sink_inst.got[j]);
      chk("rd_count", 18'(exq.size()), 18'(sfs_sink_inst.got.size()));
      $display("Stream test done");
      conclude();
   end
   // Watchdog for a hung handshake
   initial begin
      #200000;
      bad_count++;
      conclude();
   end
endmodule
